// ---- core/crf_core.sv ----
// Purpose: general registers, program counter and flag register of the cpu
// Assumes: sequencer presents one operation per start pulse; memory reads done outside
// Notes: multiply/divide values are computed by the datapath; this block times them
`timescale 1ns/1ps
module crf_core (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic op_start_in,
  input wire crf_pkg::crf_op_t op_in,
  input wire crf_pkg::crf_size_t op_size_in,
  input wire logic [3:0] dst_sel_in,
  input wire logic [3:0] src_sel_in,
  input wire logic src_imm_in,
  input wire logic [31:0] imm_in,
  input wire logic [31:0] md_result_in,
  input wire logic shift_out_bit_in,
  input wire logic bit_acc_in,
  input wire logic [7:0] flag_update_in,
  input wire logic [3:0] rd_sel_a_in,
  input wire crf_pkg::crf_size_t rd_size_a_in,
  input wire logic sp_we_in,
  input wire logic [31:0] sp_wdata_in,
  input wire logic pc_we_in,
  input wire logic [23:0] pc_wdata_in,
  input wire logic reset_vec_valid_in,
  input wire logic [23:0] reset_vec_in,
  input wire logic exc_start_in,
  input wire logic irq_in,
  input wire logic nmi_in,
  input wire logic [3:0] bcc_cond_in,
  output logic [31:0] rd_data_a_out,
  output logic [31:0] stack_pointer_out,
  output logic [23:0] program_counter_out,
  output logic [23:0] fetch_addr_out,
  output logic [7:0] condition_code_flags_out,
  output logic irq_accept_out,
  output logic branch_taken_out,
  output logic op_done_out,
  output logic busy_out
);
  import crf_pkg::*;

  logic [GPR_W-1:0] wide_gpr [NUM_GPR];
  logic [GPR_W-1:0] next_wide_gpr [NUM_GPR];
  logic [PC_W-1:0] program_counter, next_program_counter;
  logic [7:0] condition_code_flags, next_condition_code_flags;
  logic [31:0] rd_data_a, next_rd_data_a;
  logic irq_accept, next_irq_accept, branch_taken, next_branch_taken;
  logic op_done, next_op_done;
  logic busy, next_busy;
  crf_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  crf_op_t op_q, next_op_q;
  crf_size_t sz_q, next_sz_q;
  logic [3:0] dst_q, next_dst_q, src_q, next_src_q;
  logic imm_q, next_imm_q;
  logic [31:0] imm_q_d, next_imm_q_d;
  logic [7:0] upd_q, next_upd_q;

  // sized view read: width view chosen per access
  function automatic logic [31:0] view_rd(input logic [31:0] r, input crf_size_t sz,
                                          input logic hi);
    case (sz)
      CRF_SZ_B: view_rd = hi ? {24'h000000, r[15:8]} : {24'h000000, r[7:0]};
      CRF_SZ_W: view_rd = hi ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
      default: view_rd = r;
    endcase
  endfunction : view_rd

  // merge a narrow result into the 32-bit register
  function automatic logic [31:0] view_wr(input logic [31:0] r, input crf_size_t sz,
                                          input logic hi, input logic [31:0] v);
    view_wr = r;
    case (sz)
      CRF_SZ_B: if (hi) view_wr[15:8] = v[7:0]; else view_wr[7:0] = v[7:0];
      CRF_SZ_W: if (hi) view_wr[31:16] = v[15:0]; else view_wr[15:0] = v[15:0];
      default: view_wr = v;
    endcase
  endfunction : view_wr

  function automatic logic msb_of(input logic [31:0] v, input crf_size_t sz);
    case (sz)
      CRF_SZ_B: msb_of = v[7];
      CRF_SZ_W: msb_of = v[15];
      default: msb_of = v[31];
    endcase
  endfunction : msb_of

  function automatic logic [31:0] mask_of(input logic [31:0] v, input crf_size_t sz);
    case (sz)
      CRF_SZ_B: mask_of = {24'h000000, v[7:0]};
      CRF_SZ_W: mask_of = {16'h0000, v[15:0]};
      default: mask_of = v;
    endcase
  endfunction : mask_of

  // operand values and arithmetic for the operation in flight
  logic [31:0] a_v, b_v, b_eff, res, sum_lo;
  logic [32:0] sum;
  logic is_sub, is_arith, cin, carry_out, ovf, half, wr_dst;
  logic [7:0] calc_flags;
  int hb;

  always_comb begin
    a_v = view_rd(wide_gpr[dst_q[2:0]], sz_q, dst_q[3]);
    b_v = imm_q ? mask_of(imm_q_d, sz_q) : view_rd(wide_gpr[src_q[2:0]], sz_q, src_q[3]);
    is_sub = (op_q == CRF_OP_SUB) || (op_q == CRF_OP_SUBX) || (op_q == CRF_OP_CMP)
             || (op_q == CRF_OP_NEG);
    is_arith = is_sub || (op_q == CRF_OP_ADD) || (op_q == CRF_OP_ADDX);
    cin = ((op_q == CRF_OP_ADDX) || (op_q == CRF_OP_SUBX)) ? condition_code_flags[FLG_CARRY]
          : 1'b0;
    // negate works as 0 - operand
    if (op_q == CRF_OP_NEG) begin
      b_v = a_v;
      a_v = 32'h00000000;
    end
    b_eff = is_sub ? mask_of(~b_v, sz_q) : b_v;
    sum = {1'b0, a_v} + {1'b0, b_eff} + {32'h00000000, (is_sub ^ cin)};
    sum_lo = mask_of(sum[31:0], sz_q);
    case (sz_q)
      CRF_SZ_B: hb = HC_BYTE;
      CRF_SZ_W: hb = HC_WORD;
      default: hb = HC_LONG;
    endcase
    // carry into bit hb is the xor of operands and sum at that bit
    half = (a_v[hb] ^ b_eff[hb] ^ sum[hb]) ^ is_sub;
    case (sz_q)
      CRF_SZ_B: carry_out = sum[8];
      CRF_SZ_W: carry_out = sum[16];
      default: carry_out = sum[32];
    endcase
    carry_out = carry_out ^ is_sub;
    ovf = (msb_of(a_v, sz_q) == msb_of(b_eff, sz_q)) &&
          (msb_of(sum_lo, sz_q) != msb_of(a_v, sz_q));
    case (op_q)
      CRF_OP_ADD, CRF_OP_ADDX, CRF_OP_SUB, CRF_OP_SUBX, CRF_OP_CMP, CRF_OP_NEG: res = sum_lo;
      CRF_OP_MUL, CRF_OP_DIV: res = md_result_in;
      default: res = b_v;
    endcase
    wr_dst = (op_q != CRF_OP_CMP) && (op_q != CRF_OP_NONE) && (op_q != CRF_OP_SHIFT)
             && (op_q != CRF_OP_BITC) && (op_q < CRF_OP_LOAD_FLAGS || op_q > CRF_OP_XOR_FLAGS);
    calc_flags = condition_code_flags;
    calc_flags[FLG_HALF] = is_arith ? half : condition_code_flags[FLG_HALF];
    calc_flags[FLG_NEG] = msb_of(res, sz_q);
    // addx/subx only keep zero set, as multi-precision chains need
    calc_flags[FLG_ZERO] = (mask_of(res, sz_q) == 32'h00000000) &&
                           (((op_q != CRF_OP_ADDX) && (op_q != CRF_OP_SUBX)) ||
                            condition_code_flags[FLG_ZERO]);
    calc_flags[FLG_OVF] = is_arith ? ovf : 1'b0;
    calc_flags[FLG_CARRY] = is_arith ? carry_out :
                            (op_q == CRF_OP_SHIFT) ? shift_out_bit_in :
                            (op_q == CRF_OP_BITC) ? bit_acc_in : condition_code_flags[FLG_CARRY];
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_op_q = op_q;
    next_sz_q = sz_q;
    next_dst_q = dst_q;
    next_src_q = src_q;
    next_imm_q = imm_q;
    next_imm_q_d = imm_q_d;
    next_upd_q = upd_q;
    next_op_done = 1'b0;
    next_wide_gpr = wide_gpr;
    next_program_counter = program_counter;
    next_condition_code_flags = condition_code_flags;
    if (pc_we_in) begin
      next_program_counter = pc_wdata_in;
    end
    if (sp_we_in) begin
      next_wide_gpr[SP_IDX] = sp_wdata_in;
    end
    case (state)
      CRF_IDLE: begin
        if (op_start_in) begin
          next_state = CRF_BUSY;
          next_op_q = op_in;
          next_sz_q = op_size_in;
          next_dst_q = dst_sel_in;
          next_src_q = src_sel_in;
          next_imm_q = src_imm_in;
          next_imm_q_d = imm_in;
          next_upd_q = flag_update_in;
          // states counted from the start state; result lands in the last one
          case (op_in)
            CRF_OP_MUL, CRF_OP_DIV: next_cnt = (op_size_in == CRF_SZ_B) ?
                                    MD_SHORT_STATES - 5'h02 : MD_LONG_STATES - 5'h02;
            default: next_cnt = ADD_STATES - 5'h02;
          endcase
        end
      end
      CRF_BUSY: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01;
        end else begin
          next_state = CRF_IDLE;
          next_op_done = 1'b1;
          if (wr_dst) begin
            next_wide_gpr[dst_q[2:0]] = view_wr(wide_gpr[dst_q[2:0]],
              (op_q == CRF_OP_MUL || op_q == CRF_OP_DIV) ? crf_size_t'(sz_q + 2'h1) : sz_q,
              dst_q[3], res);
          end
          case (op_q)
            CRF_OP_LOAD_FLAGS: next_condition_code_flags = b_v[7:0];
            CRF_OP_AND_FLAGS: next_condition_code_flags = condition_code_flags & b_v[7:0];
            CRF_OP_OR_FLAGS: next_condition_code_flags = condition_code_flags | b_v[7:0];
            CRF_OP_XOR_FLAGS: next_condition_code_flags = condition_code_flags ^ b_v[7:0];
            default: begin
              // only flags the instruction names move, same state as result
              next_condition_code_flags = (calc_flags & upd_q) |
                                          (condition_code_flags & ~upd_q);
            end
          endcase
        end
      end
      default: next_state = CRF_IDLE;
    endcase
    // busy is registered so the port comes straight from a flop
    next_busy = (next_state == CRF_BUSY);
    if (exc_start_in) begin
      next_condition_code_flags[FLG_MASK] = 1'b1;
    end
    if (reset_vec_valid_in) begin
      next_program_counter = reset_vec_in;
      next_condition_code_flags[FLG_MASK] = 1'b1;
    end
  end

  always_comb begin
    next_rd_data_a = view_rd(next_wide_gpr[rd_sel_a_in[2:0]], rd_size_a_in, rd_sel_a_in[3]);
    next_irq_accept = nmi_in || (irq_in && !next_condition_code_flags[FLG_MASK]);
    // branch conditions from n, z, v, c only
    case (bcc_cond_in)
      4'h0: next_branch_taken = 1'b1;
      4'h1: next_branch_taken = 1'b0;
      4'h2: next_branch_taken = !(next_condition_code_flags[FLG_CARRY] ||
                                  next_condition_code_flags[FLG_ZERO]);
      4'h3: next_branch_taken = next_condition_code_flags[FLG_CARRY] ||
                                next_condition_code_flags[FLG_ZERO];
      4'h4: next_branch_taken = !next_condition_code_flags[FLG_CARRY];
      4'h5: next_branch_taken = next_condition_code_flags[FLG_CARRY];
      4'h6: next_branch_taken = !next_condition_code_flags[FLG_ZERO];
      4'h7: next_branch_taken = next_condition_code_flags[FLG_ZERO];
      4'h8: next_branch_taken = !next_condition_code_flags[FLG_OVF];
      4'h9: next_branch_taken = next_condition_code_flags[FLG_OVF];
      4'ha: next_branch_taken = !next_condition_code_flags[FLG_NEG];
      4'hb: next_branch_taken = next_condition_code_flags[FLG_NEG];
      4'hc: next_branch_taken = next_condition_code_flags[FLG_NEG] ==
                                next_condition_code_flags[FLG_OVF];
      4'hd: next_branch_taken = next_condition_code_flags[FLG_NEG] !=
                                next_condition_code_flags[FLG_OVF];
      4'he: next_branch_taken = !next_condition_code_flags[FLG_ZERO] &&
                                (next_condition_code_flags[FLG_NEG] ==
                                 next_condition_code_flags[FLG_OVF]);
      default: next_branch_taken = next_condition_code_flags[FLG_ZERO] ||
                                   (next_condition_code_flags[FLG_NEG] !=
                                    next_condition_code_flags[FLG_OVF]);
    endcase
  end

  // general registers are not cleared: software must not rely on them; flags reset with only the mask bit set
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= CRF_IDLE;
      cnt <= 5'h00;
      op_q <= CRF_OP_NONE;
      sz_q <= CRF_SZ_B;
      dst_q <= 4'h0;
      src_q <= 4'h0;
      imm_q <= 1'b0;
      imm_q_d <= 32'h00000000;
      upd_q <= 8'h00;
      op_done <= 1'b0;
      program_counter <= 24'h000000;
      condition_code_flags <= 8'h80;
      busy <= 1'b0;
      rd_data_a <= 32'h00000000;
      irq_accept <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op_q <= next_op_q;
      sz_q <= next_sz_q;
      dst_q <= next_dst_q;
      src_q <= next_src_q;
      imm_q <= next_imm_q;
      imm_q_d <= next_imm_q_d;
      upd_q <= next_upd_q;
      op_done <= next_op_done;
      program_counter <= next_program_counter;
      condition_code_flags <= next_condition_code_flags;
      rd_data_a <= next_rd_data_a;
      irq_accept <= next_irq_accept;
      branch_taken <= next_branch_taken;
      busy <= next_busy;
    end
  end

  always_ff @(posedge mclk_in) begin
    wide_gpr <= next_wide_gpr;
  end

  always_comb begin
    rd_data_a_out = rd_data_a;
    stack_pointer_out = wide_gpr[SP_IDX];
    program_counter_out = program_counter;
    fetch_addr_out = {program_counter[PC_W-1:1], 1'b0};
    condition_code_flags_out = condition_code_flags;
    irq_accept_out = irq_accept;
    branch_taken_out = branch_taken;
    op_done_out = op_done;
    busy_out = busy;
  end
endmodule : crf_core

// ---- core/crf_pkg.sv ----
// Purpose: constants and types for the cpu register file and flag unit
// Assumes: one 20 MHz clock, one cpu state per clock
// Notes: Operation list follows
// Operation
// - eight identical 32-bit general registers, usable for addresses and data.
// - each register splits into upper extended half and lower half.
// - lower half splits again into high byte and low byte.
// - width view chosen per register on each access.
// - register seven doubles as stack pointer for exceptions and calls.
// - 24-bit program counter holds next instruction address.
// - fetch address forces program counter bit zero to zero.
// - reset sequence loads program counter from reset vector data.
// - reset sequence sets mask bit; other flag bits left as they are; rst_in clears them, loading flags with 80h.
// - mask bit blocks maskable interrupts; non-maskable always accepted.
// - every exception sequence sets the mask bit first.
// - bit 6 is a spare software bit without hardware effect.
// - flags loadable, storable, and-able, or-able, xor-able as a whole.
// - branch conditions use negative, zero, overflow and carry.
// - byte arithmetic sets half-carry from carry or borrow at bit 3.
// - word arithmetic sets half-carry from carry or borrow at bit 11.
// - each instruction chooses which flags it updates.
// - register add and subtract finish in 2 states.
// - 8x8 multiply and 16/8 divide finish in 14 states.
// - 16x16 multiply and 32/16 divide finish in 22 states.
// - linear 16 Mbyte space for program and data.
// - negative flag takes result sign bit.
// - zero flag set for zero result, cleared otherwise; addx/subx only keep it set on a zero result and never set it.
// - overflow flag set on arithmetic overflow, cleared otherwise.
// - carry shows carry, borrow, shifted bit, or bit accumulator.
package crf_pkg;
  localparam int NUM_GPR = 8;
  localparam int GPR_W = 32;
  localparam int PC_W = 24;
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam int FLG_MASK = 7;
  localparam int FLG_SPARE = 6;
  localparam int FLG_HALF = 5;
  localparam int FLG_NEG = 3;
  localparam int FLG_ZERO = 2;
  localparam int FLG_OVF = 1;
  localparam int FLG_CARRY = 0;
  localparam int HC_BYTE = 4;
  localparam int HC_WORD = 12;
  localparam int HC_LONG = 28;
  localparam logic [4:0] ADD_STATES = 5'h02;
  localparam logic [4:0] MD_SHORT_STATES = 5'h0e;
  localparam logic [4:0] MD_LONG_STATES = 5'h16;
  typedef enum logic [1:0] {CRF_SZ_B, CRF_SZ_W, CRF_SZ_L} crf_size_t;
  // byte views: sel[3] picks high byte of lower half, word views: sel[3] picks extended half
  typedef enum logic [3:0] {
    CRF_OP_NONE, CRF_OP_ADD, CRF_OP_ADDX, CRF_OP_SUB, CRF_OP_SUBX, CRF_OP_CMP,
    CRF_OP_NEG, CRF_OP_MOV, CRF_OP_LOAD_FLAGS, CRF_OP_AND_FLAGS, CRF_OP_OR_FLAGS,
    CRF_OP_XOR_FLAGS,
    CRF_OP_MUL, CRF_OP_DIV, CRF_OP_SHIFT, CRF_OP_BITC
  } crf_op_t;
  typedef enum {CRF_IDLE, CRF_BUSY} crf_state_t;
endpackage : crf_pkg

// ---- dv/crf_core_sva.sv ----
// Purpose: timing and flag checks on the register file ports
// Assumes: single clock domain, async active-high reset
// Notes: bound onto every crf_core instance
`timescale 1ns/1ps
module crf_core_sva
  import crf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic op_start_in,
  input wire crf_pkg::crf_op_t op_in,
  input wire crf_pkg::crf_size_t op_size_in,
  input wire logic src_imm_in,
  input wire logic [31:0] imm_in,
  input wire logic sp_we_in,
  input wire logic [31:0] sp_wdata_in,
  input wire logic pc_we_in,
  input wire logic [23:0] pc_wdata_in,
  input wire logic reset_vec_valid_in,
  input wire logic [23:0] reset_vec_in,
  input wire logic exc_start_in,
  input wire logic irq_in,
  input wire logic nmi_in,
  input wire logic [31:0] stack_pointer_out,
  input wire logic [23:0] program_counter_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic [7:0] condition_code_flags_out,
  input wire logic irq_accept_out,
  input wire logic op_done_out,
  input wire logic busy_out
);
  logic take;
  assign take = op_start_in && !busy_out;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  add_done_a: assert property (take && op_in == CRF_OP_ADD
    |=> busy_out ##1 (op_done_out && !busy_out)) else $error("add did not finish in two states");
  mul_short_a: assert property (take && op_in == CRF_OP_MUL && op_size_in == CRF_SZ_B
    |=> busy_out [*8] ##1 busy_out [*5] ##1 op_done_out)
    else $error("short multiply timing wrong");
  mul_long_a: assert property (take && op_in == CRF_OP_MUL && op_size_in == CRF_SZ_W
    |-> ##21 !op_done_out ##1 op_done_out) else $error("long multiply timing wrong");
  fetch_even_a: assert property (fetch_addr_out == {program_counter_out[23:1], 1'b0})
    else $error("fetch address not even copy of counter");
  vec_load_a: assert property (reset_vec_valid_in |=> program_counter_out == $past(reset_vec_in)
    && condition_code_flags_out[FLG_MASK]) else $error("reset vector load wrong");
  pc_load_a: assert property (pc_we_in && !reset_vec_valid_in
    |=> program_counter_out == $past(pc_wdata_in)) else $error("counter load wrong");
  exc_mask_a: assert property (exc_start_in |=> condition_code_flags_out[FLG_MASK])
    else $error("exception did not set mask");
  irq_gate_a: assert property (!$past(rst_in) |-> irq_accept_out == ($past(nmi_in)
    || ($past(irq_in) && !condition_code_flags_out[FLG_MASK]))) else $error("irq gating wrong");
  flag_load_a: assert property (take && op_in == CRF_OP_LOAD_FLAGS && src_imm_in
    |=> ##1 op_done_out
    && {24'h000000, condition_code_flags_out} == ($past(imm_in, 2) & 32'h000000ff))
    else $error("flag load wrong");
  sp_write_a: assert property (sp_we_in && !busy_out
    |=> stack_pointer_out == $past(sp_wdata_in)) else $error("stack pointer write lost");
endmodule : crf_core_sva

bind crf_core crf_core_sva u_sva (.mclk_in, .rst_in, .op_start_in, .op_in, .op_size_in,
  .src_imm_in, .imm_in, .sp_we_in, .sp_wdata_in, .pc_we_in, .pc_wdata_in, .reset_vec_valid_in,
  .reset_vec_in, .exc_start_in, .irq_in, .nmi_in, .stack_pointer_out, .program_counter_out,
  .fetch_addr_out, .condition_code_flags_out, .irq_accept_out, .op_done_out, .busy_out);

// ---- dv/cpu_register_file_ccr_test.sv ----
// Purpose: directed bench for the register file and flag unit
// Assumes: 20 MHz clock, reset held 16 cycles
// Notes: every op uses the immediate source; reads use the full view
`timescale 1ns/1ps
module cpu_register_file_ccr_test;
  import crf_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1, op_start_in = 1'b0, src_imm_in = 1'b1;
  logic shift_out_bit_in = 1'b0, bit_acc_in = 1'b0, sp_we_in = 1'b0, pc_we_in = 1'b0;
  logic reset_vec_valid_in = 1'b0, exc_start_in = 1'b0, irq_in = 1'b0, nmi_in = 1'b0;
  crf_op_t op_in = CRF_OP_NONE;
  crf_size_t op_size_in = CRF_SZ_B, rd_size_a_in = CRF_SZ_L;
  logic [3:0] dst_sel_in = 4'h0, src_sel_in = 4'h0, rd_sel_a_in = 4'h0, bcc_cond_in = 4'h0;
  logic [31:0] imm_in = 32'h0, md_result_in = 32'h0, sp_wdata_in = 32'h0;
  logic [7:0] flag_update_in = 8'h00;
  logic [23:0] pc_wdata_in = 24'h0, reset_vec_in = 24'h0;
  logic [31:0] rd_data_a_out, stack_pointer_out;
  logic [23:0] program_counter_out, fetch_addr_out;
  logic [7:0] condition_code_flags_out;
  logic irq_accept_out, branch_taken_out, op_done_out, busy_out;
  int n_errors = 0, n_tests = 0, c;
  crf_core uut (.mclk_in, .rst_in, .op_start_in, .op_in, .op_size_in, .dst_sel_in, .src_sel_in,
    .src_imm_in, .imm_in, .md_result_in, .shift_out_bit_in, .bit_acc_in, .flag_update_in,
    .rd_sel_a_in, .rd_size_a_in, .sp_we_in, .sp_wdata_in, .pc_we_in, .pc_wdata_in,
    .reset_vec_valid_in, .reset_vec_in, .exc_start_in, .irq_in, .nmi_in, .bcc_cond_in,
    .rd_data_a_out, .stack_pointer_out, .program_counter_out, .fetch_addr_out,
    .condition_code_flags_out, .irq_accept_out, .branch_taken_out, .op_done_out, .busy_out);
  always #25 mclk_in = ~mclk_in;
  task give_verdict();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  // bounded wait: a hung sequencer ends the run instead of stalling it
  task run_op(input crf_op_t op, input crf_size_t sz, input logic [3:0] dst,
      input logic [31:0] imm, input logic [7:0] upd);
    @(posedge mclk_in);
    op_start_in <= 1'b1;
    op_in <= op;
    op_size_in <= sz;
    dst_sel_in <= dst;
    imm_in <= imm;
    flag_update_in <= upd;
    @(posedge mclk_in);
    op_start_in <= 1'b0;
    c = 0;
    do begin
      @(posedge mclk_in);
      #1;
      c++;
    end while (op_done_out !== 1'b1 && c < 40);
    if (c >= 40) begin
      n_errors++;
      give_verdict();
    end
  endtask : run_op
  task chk_reg(input logic [3:0] sel, input logic [31:0] exp);
    @(posedge mclk_in);
    rd_sel_a_in <= sel;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(rd_data_a_out, exp);
  endtask : chk_reg
  task t_reset_pc();
    @(posedge mclk_in);
    #1;
    chk({24'h0, condition_code_flags_out}, 32'h80);
    chk({8'h0, program_counter_out}, 32'h0);
    @(posedge mclk_in);
    reset_vec_valid_in <= 1'b1;
    reset_vec_in <= 24'h012345;
    @(posedge mclk_in);
    reset_vec_valid_in <= 1'b0;
    pc_we_in <= 1'b1;
    pc_wdata_in <= 24'habcdef;
    #1;
    chk({8'h0, program_counter_out}, 32'h012345);
    chk({8'h0, fetch_addr_out}, 32'h012344);
    @(posedge mclk_in);
    pc_we_in <= 1'b0;
    #1;
    chk({8'h0, fetch_addr_out}, 32'habcdee);
    $display("test reset and counter done");
  endtask : t_reset_pc
  task t_views();
    run_op(CRF_OP_MOV, CRF_SZ_L, 4'h1, 32'h11223344, 8'h00);
    run_op(CRF_OP_MOV, CRF_SZ_B, 4'h9, 32'h000000ab, 8'h00);
    chk_reg(4'h1, 32'h1122ab44);
    run_op(CRF_OP_MOV, CRF_SZ_B, 4'h1, 32'h000000cd, 8'h00);
    run_op(CRF_OP_MOV, CRF_SZ_W, 4'h9, 32'h0000beef, 8'h00);
    chk_reg(4'h1, 32'hbeefabcd);
    $display("test views done");
  endtask : t_views
  task t_arith();
    logic [31:0] av [8] = '{32'h0f, 32'h7f, 32'hff, 32'h10, 32'h0fff, 32'h0fffffff,
      32'h7fffffff, 32'h0};
    logic [7:0] fv [8] = '{8'h20, 8'h2a, 8'h25, 8'h20, 8'h20, 8'h20, 8'h2a, 8'h29};
    logic [1:0] sv [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [31:0] m;
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      m = (sv[i] == 2'h0) ? 32'hff : (sv[i] == 2'h1) ? 32'hffff : 32'hffffffff;
      r = (i == 3 || i == 7) ? av[i] - 32'h1 : av[i] + 32'h1;
      run_op(CRF_OP_MOV, CRF_SZ_L, 4'h3, av[i], 8'h00);
      run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, 32'h0, 8'h00);
      run_op((i == 3 || i == 7) ? CRF_OP_SUB : CRF_OP_ADD, crf_size_t'(sv[i]), 4'h3, 32'h1, 8'h2f);
      chk(32'(c), 32'h1);
      chk({24'h0, condition_code_flags_out}, {24'h0, fv[i]});
      chk_reg(4'h3, (av[i] & ~m) | (r & m));
    end
    $display("test arithmetic done");
  endtask : t_arith
  task t_muldiv();
    for (int i = 0; i < 2; i++) begin
      run_op(CRF_OP_MOV, CRF_SZ_L, 4'h2, 32'haaaa5555, 8'h00);
      @(posedge mclk_in);
      md_result_in <= 32'h00001234;
      run_op(i ? CRF_OP_DIV : CRF_OP_MUL, CRF_SZ_B, 4'h2, 32'h0, 8'h00);
      chk(32'(c), 32'hd);
      chk_reg(4'h2, 32'haaaa1234);
      @(posedge mclk_in);
      md_result_in <= 32'h12345678;
      run_op(i ? CRF_OP_DIV : CRF_OP_MUL, CRF_SZ_W, 4'h2, 32'h0, 8'h00);
      chk(32'(c), 32'h15);
      chk_reg(4'h2, 32'h12345678);
    end
    $display("test multiply divide done");
  endtask : t_muldiv
  task t_flags();
    crf_op_t ov [4] = '{CRF_OP_LOAD_FLAGS, CRF_OP_OR_FLAGS, CRF_OP_AND_FLAGS, CRF_OP_XOR_FLAGS};
    logic [7:0] iv [4] = '{8'h40, 8'h81, 8'h7f, 8'hff};
    logic [7:0] ev [4] = '{8'h40, 8'hc1, 8'h41, 8'hbe};
    logic [15:0] bv [2] = '{16'h9599, 16'ha969};
    logic [7:0] fl [2] = '{8'h04, 8'h09};
    for (int i = 0; i < 4; i++) begin
      run_op(ov[i], CRF_SZ_B, 4'h0, {24'h0, iv[i]}, 8'h00);
      chk({24'h0, condition_code_flags_out}, {24'h0, ev[i]});
    end
    for (int f = 0; f < 2; f++) begin
      run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, {24'h0, fl[f]}, 8'h00);
      for (int k = 0; k < 16; k++) begin
        @(posedge mclk_in);
        bcc_cond_in <= 4'(k);
        repeat (2) @(posedge mclk_in);
        #1;
        chk({31'h0, branch_taken_out}, {31'h0, bv[f][k]});
      end
    end
    $display("test flags and branches done");
  endtask : t_flags
  task t_irq_sp();
    run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, 32'h0, 8'h00);
    @(posedge mclk_in);
    irq_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({31'h0, irq_accept_out}, 32'h1);
    run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, 32'h80, 8'h00);
    chk({31'h0, irq_accept_out}, 32'h0);
    @(posedge mclk_in);
    nmi_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({31'h0, irq_accept_out}, 32'h1);
    @(posedge mclk_in);
    nmi_in <= 1'b0;
    irq_in <= 1'b0;
    run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, 32'h0, 8'h00);
    @(posedge mclk_in);
    exc_start_in <= 1'b1;
    sp_we_in <= 1'b1;
    sp_wdata_in <= 32'h00fffe00;
    @(posedge mclk_in);
    exc_start_in <= 1'b0;
    sp_we_in <= 1'b0;
    #1;
    chk({31'h0, condition_code_flags_out[FLG_MASK]}, 32'h1);
    chk(stack_pointer_out, 32'h00fffe00);
    run_op(CRF_OP_MOV, CRF_SZ_B, 4'h7, 32'h11, 8'h00);
    chk(stack_pointer_out, 32'h00fffe11);
    $display("test interrupts and stack done");
  endtask : t_irq_sp
  // carry from shift and bit ops, compare without write, negate, extend add
  task t_carry();
    run_op(CRF_OP_LOAD_FLAGS, CRF_SZ_B, 4'h0, 32'h0, 8'h00);
    @(posedge mclk_in);
    shift_out_bit_in <= 1'b1;
    run_op(CRF_OP_SHIFT, CRF_SZ_B, 4'h0, 32'h0, 8'h01);
    chk({24'h0, condition_code_flags_out}, 32'h01);
    run_op(CRF_OP_BITC, CRF_SZ_B, 4'h0, 32'h0, 8'h01);
    chk({24'h0, condition_code_flags_out}, 32'h00);
    run_op(CRF_OP_MOV, CRF_SZ_L, 4'h4, 32'h5, 8'h00);
    run_op(CRF_OP_CMP, CRF_SZ_B, 4'h4, 32'h5, 8'h2f);
    chk({24'h0, condition_code_flags_out}, 32'h04);
    run_op(CRF_OP_NEG, CRF_SZ_B, 4'h4, 32'h0, 8'h2f);
    chk({24'h0, condition_code_flags_out}, 32'h29);
    run_op(CRF_OP_ADDX, CRF_SZ_B, 4'h4, 32'h4, 8'h2f);
    chk({24'h0, condition_code_flags_out}, 32'h21);
    chk_reg(4'h4, 32'h00000000);
    $display("test carry sources done");
  endtask : t_carry
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset_pc();
    t_views();
    t_arith();
    t_muldiv();
    t_flags();
    t_irq_sp();
    t_carry();
    give_verdict();
  end
endmodule : cpu_register_file_ccr_test
